/* File: hw/lac_fifo.sv */
// Sample FIFO with valid and ready on both sides
`timescale 1ns/100ps
module lac_fifo
  import lac_pkg::*;
#(
  parameter int W     = 37,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // Drain side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  wire           push;
  wire           pop;

  assign o_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_valid = (count_reg != '0);
  assign o_data  = mem_reg[rd_ptr_reg];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  // ==========================================================
  // Pointers wrap at DEPTH so any depth works
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= i_data;
  end
endmodule // lac_fifo

/* File: hw/lac_front.sv */
// Acquisition unit front end for one pod pair
`timescale 1ns/100ps
// How it works
// - Each pod brings sixteen data pins plus one clock-or-data pin.
// - The clock-or-data pin is data unless it is an active state clock.
// - Only the lowest NCLK_CAP state clock lines may be enabled.
// - One threshold per pod covers its clock pin and data pins alike.
// - Two nine-channel comparator groups per pod resolve all its pins.
// - Eight threshold registers, one per pod, each written independently.
// - One unit captures all 34 channels of its pod pair.
// - All six state clocks reach the unit; it makes its own sample edge.
// - Every run starts with delay-tap optimisation before storing data.
// - Fast timing samples on the ticks of the four-phase clock.
// - Slow timing: one master unit divides; all units sample its clock.
// - The shared sync pulse realigns the phase counter of every unit.
// - Self-test drives a serial pattern on all comparator channels.
module lac_front
  import lac_pkg::*;
#(
  parameter int NCLK_CAP = MAX_CLKS,
  parameter int CD_BASE  = 0
)
(
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Probe and clock pins
  input  wire logic [NUM_PODS*POD_W-1:0]   i_pod,
  input  wire logic [NUM_SCLK-1:0]         i_sclk,
  input  wire logic                        i_sync,
  input  wire logic                        i_slow_clk,
  // Configuration
  input  wire logic                        i_run,
  input  wire logic                        i_timing,
  input  wire logic                        i_slow_sel,
  input  wire logic                        i_div_master,
  input  wire logic [DIV_W-1:0]            i_div,
  input  wire logic [3:0]                  i_phase_mask,
  input  wire logic [NUM_SCLK-1:0]         i_clk_en,
  input  wire logic                        i_test,
  // Threshold programming
  input  wire logic                        i_thr_wr,
  input  wire logic [2:0]                  i_thr_idx,
  input  wire logic [THR_W-1:0]            i_thr_val,
  // Sample stream
  input  wire logic                        i_ready,
  output lac_smp_t                         o_data,
  output logic                             o_valid,
  // Status and pins out
  output logic [NUM_THR*THR_W-1:0]         o_thresh,
  output logic                             o_slow_clk,
  output logic                             o_running,
  output logic [TAP_W-1:0]                 o_tap,
  output logic                             o_overrun,
  output logic                             o_test_err
);
  localparam logic [NUM_SCLK-1:0] CAP_MASK =
    NUM_SCLK'((1 << NCLK_CAP) - 1);

  // ==========================================================
  // Functions
  // Nine-channel comparator groups
  function automatic logic [UNIT_W-1:0] expand(input logic [3:0] b);
    logic [UNIT_W-1:0] w;
    w = '0;
    for (int i = 0; i < UNIT_W; i++)
      w[i] = b[2*(i/POD_W) + ((i%POD_W) >= CMP_W ? 1 : 0)];
    return w;
  endfunction

  function automatic logic [TAP_W-1:0] best_tap(
    input logic [TAPS*OPT_W-1:0] c);
    logic [TAP_W-1:0] t;
    logic [OPT_W-1:0] m;
    t = TAP_RST;
    m = c[OPT_W-1:0];
    for (int i = 1; i < TAPS-1; i++)
      if (c[i*OPT_W +: OPT_W] < m)
      begin
        m = c[i*OPT_W +: OPT_W];
        t = TAP_W'(i);
      end
    return t;
  endfunction

  // ==========================================================
  // Registers
  lac_state_t                state_reg;
  logic [NUM_PODS*POD_W-1:0] pod_s1_reg;
  logic [NUM_PODS*POD_W-1:0] pod_s2_reg;
  logic [NUM_SCLK-1:0]       sclk_s1_reg;
  logic [NUM_SCLK-1:0]       sclk_s2_reg;
  logic [NUM_SCLK-1:0]       sclk_prev_reg;
  logic [2:0]                sync_reg;
  logic [2:0]                slow_reg;
  logic [THR_W-1:0]          thr_reg [NUM_THR];
  logic                      timing_reg;
  logic                      slow_sel_reg;
  logic                      master_reg;
  logic [1:0]                phase_reg;
  logic [DIV_W-1:0]          div_cnt_reg;
  logic                      slow_out_reg;
  logic [7:0]                lfsr_reg;
  logic [UNIT_W-1:0]         hist_reg [TAPS];
  logic [3:0]                exp_reg [TAPS];
  logic [TAP_W-1:0]          tap_reg;
  logic [OPT_W-1:0]          opt_cnt_reg;
  logic [TAPS*OPT_W-1:0]     tr_cnt_reg;
  logic                      overrun_reg;
  logic                      test_err_reg;
  logic                      run_prev_reg;
  lac_smp_t                  out_data_reg;
  logic                      out_valid_reg;

  // ==========================================================
  // Decode
  wire [NUM_SCLK-1:0] clk_act;
  wire [NUM_SCLK-1:0] sclk_rise;
  wire                state_edge;
  wire                sync_rise;
  wire                slow_rise;
  wire                fast_en;
  wire                sample_en;
  wire [UNIT_W-1:0]   pod_word;
  wire [UNIT_W-1:0]   front_word;
  wire [UNIT_W-1:0]   sel_word;
  wire [UNIT_W-1:0]   exp_word;
  wire                run_start;
  wire                opt_done;
  wire                push;
  wire                fifo_ready;
  wire                fifo_valid;
  lac_smp_t           fifo_data;
  lac_smp_t           push_data;
  wire                out_ready;

  assign clk_act    = i_clk_en & CAP_MASK;
  assign sclk_rise  = sclk_s2_reg & ~sclk_prev_reg & clk_act;
  assign state_edge = |sclk_rise;
  assign sync_rise  = sync_reg[1] & ~sync_reg[2];
  assign slow_rise  = slow_reg[1] & ~slow_reg[2];
  assign fast_en    = i_phase_mask[phase_reg];
  assign sample_en  = !timing_reg ? state_edge :
                      (slow_sel_reg ? slow_rise : fast_en);

  genvar p;
  generate
    for (p = 0; p < NUM_PODS; p++)
    begin : g_pod
      wire cd_is_clk;
      assign cd_is_clk = !timing_reg && clk_act[CD_BASE+p];
      assign pod_word[p*POD_W +: CD_BIT] = pod_s2_reg[p*POD_W +: CD_BIT];
      assign pod_word[p*POD_W+CD_BIT] =
        pod_s2_reg[p*POD_W+CD_BIT] & ~cd_is_clk;
    end
  endgenerate

  assign front_word = i_test ? expand(lfsr_reg[3:0]) : pod_word;
  assign sel_word   = hist_reg[tap_reg];
  assign exp_word   = expand(exp_reg[tap_reg]);
  assign run_start  = i_run && !run_prev_reg && (state_reg == ST_IDLE);
  assign opt_done   = (opt_cnt_reg == OPT_EDGES);
  assign push       = (state_reg == ST_RUN) && sample_en;
  assign push_data  = '{data: sel_word, phase: phase_reg, tst: i_test};
  assign out_ready  = !out_valid_reg || i_ready;

  assign o_data     = out_data_reg;
  assign o_valid    = out_valid_reg;
  assign o_slow_clk = slow_out_reg;
  assign o_running  = state_reg[2]; // One-hot run bit
  assign o_tap      = tap_reg;
  assign o_overrun  = overrun_reg;
  assign o_test_err = test_err_reg;

  genvar t;
  generate
    for (t = 0; t < NUM_THR; t++)
    begin : g_thr
      assign o_thresh[t*THR_W +: THR_W] = thr_reg[t];
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge i_clk)
  begin
    pod_s1_reg    <= i_pod;
    pod_s2_reg    <= pod_s1_reg;
    sclk_s1_reg   <= i_sclk;
    sclk_s2_reg   <= sclk_s1_reg;
    sclk_prev_reg <= sclk_s2_reg;
    sync_reg      <= {sync_reg[1:0], i_sync};
    slow_reg      <= {slow_reg[1:0], i_slow_clk};
  end

  // ==========================================================
  // Thresholds
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      for (int i = 0; i < NUM_THR; i++)
        thr_reg[i] <= THR_RST;
    else if (i_thr_wr)
      thr_reg[i_thr_idx] <= i_thr_val;
  end

  // ==========================================================
  // Run control
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_reg    <= ST_IDLE;
      run_prev_reg <= 1'b0;
      timing_reg   <= 1'b0;
      slow_sel_reg <= 1'b0;
      master_reg   <= 1'b0;
    end
    else
    begin
      run_prev_reg <= i_run;
      unique case (state_reg)
        ST_IDLE:
        begin
          timing_reg   <= i_timing;
          slow_sel_reg <= i_slow_sel;
          master_reg   <= i_div_master;
          if (run_start)
            state_reg <= ST_OPT;
        end
        ST_OPT:
          if (!i_run)
            state_reg <= ST_IDLE;
          else if (opt_done)
            state_reg <= ST_RUN;
        ST_RUN:
          if (!i_run)
            state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Delay taps and optimisation
  // Taps are sample-history depths; the one whose data changed least
  // around the clock edge is the one nearest the valid window.
  always_ff @(posedge i_clk)
  begin
    hist_reg[0] <= front_word;
    exp_reg[0]  <= lfsr_reg[3:0];
    for (int i = 1; i < TAPS; i++)
    begin
      hist_reg[i] <= hist_reg[i-1];
      exp_reg[i]  <= exp_reg[i-1];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || run_start)
    begin
      opt_cnt_reg <= '0;
      tr_cnt_reg  <= '0;
      if (i_rst)
        tap_reg <= TAP_RST;
    end
    else if (state_reg == ST_OPT && sample_en && !opt_done)
    begin
      opt_cnt_reg <= opt_cnt_reg + 1'b1;
      for (int i = 0; i < TAPS-1; i++)
        if (hist_reg[i] != hist_reg[i+1])
          tr_cnt_reg[i*OPT_W +: OPT_W] <=
            tr_cnt_reg[i*OPT_W +: OPT_W] + 1'b1;
    end
    else if (state_reg == ST_OPT && opt_done)
      tap_reg <= best_tap(tr_cnt_reg);
  end

  // ==========================================================
  // Four-phase tick and slow divider
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      phase_reg    <= PHASE_RST;
      div_cnt_reg  <= DIV_RST;
      slow_out_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= sync_rise ? PHASE_RST : phase_reg + 1'b1;
      if (!(master_reg && timing_reg && slow_sel_reg) ||
          state_reg == ST_IDLE)
      begin
        div_cnt_reg  <= DIV_RST;
        slow_out_reg <= 1'b0;
      end
      else if (phase_reg == PHASE_RST)
      begin
        if (div_cnt_reg == i_div)
        begin
          div_cnt_reg  <= DIV_RST;
          slow_out_reg <= ~slow_out_reg;
        end
        else
          div_cnt_reg <= div_cnt_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // Self-test pattern and check
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      lfsr_reg     <= LFSR_SEED;
      test_err_reg <= 1'b0;
      overrun_reg  <= 1'b0;
    end
    else
    begin
      lfsr_reg <= {lfsr_reg[6:0],
                   lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      if (run_start)
      begin
        test_err_reg <= 1'b0;
        overrun_reg  <= 1'b0;
      end
      if (push && i_test && sel_word != exp_word)
        test_err_reg <= 1'b1;
      // Target cannot be stalled, so a full FIFO loses the sample
      if (push && !fifo_ready)
        overrun_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Storage FIFO and output register
  lac_fifo #(
    .W     ($bits(lac_smp_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (push),
    .i_data  (push_data),
    .o_ready (fifo_ready),
    .o_valid (fifo_valid),
    .o_data  (fifo_data),
    .i_ready (out_ready)
  );

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end
    else if (out_ready)
    begin
      out_valid_reg <= fifo_valid;
      out_data_reg  <= fifo_data;
    end
  end

  // ==========================================================
  // Assertions
  sequence s_start;
    state_reg == ST_IDLE ##1 state_reg != ST_IDLE;
  endsequence

  sequence s_opt_then_run;
    state_reg == ST_OPT [*1] ##[1:1000] state_reg != ST_OPT;
  endsequence

  AST_CD_DATA: assert property (@(posedge i_clk) disable iff (i_rst)
    timing_reg && !i_test |-> front_word[CD_BIT] == pod_s2_reg[CD_BIT])
    else $error("clock-or-data pin lost in timing mode");

  AST_CLK_CAP: assert property (@(posedge i_clk) disable iff (i_rst)
    (sclk_rise & ~CAP_MASK) == '0)
    else $error("state clock above cap produced an edge");

  AST_THR_WR: assert property (@(posedge i_clk) disable iff (i_rst)
    i_thr_wr |=> o_thresh[$past(i_thr_idx)*THR_W +: THR_W]
                 == $past(i_thr_val))
    else $error("threshold write not applied");

  AST_OPT_FIRST: assert property (@(posedge i_clk) disable iff (i_rst)
    s_start |-> state_reg == ST_OPT)
    else $error("run began without optimisation");

  AST_OPT_NO_STORE: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == ST_OPT |-> !push)
    else $error("data stored during optimisation");

  AST_OPT_BOUND: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == ST_OPT && opt_done |=> state_reg != ST_OPT)
    else $error("optimisation did not finish");

  AST_SYNC: assert property (@(posedge i_clk) disable iff (i_rst)
    sync_rise |=> phase_reg == PHASE_RST ##1 phase_reg == 2'h1 || sync_rise)
    else $error("phase not realigned by sync");

  AST_SLAVE_QUIET: assert property (@(posedge i_clk) disable iff (i_rst)
    !master_reg |=> !slow_out_reg)
    else $error("non-master unit drives slow clock");

  AST_MODE_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg != ST_IDLE |=> $stable(timing_reg) && $stable(slow_sel_reg))
    else $error("clock mode changed while running");

  AST_TEST_INJ: assert property (@(posedge i_clk) disable iff (i_rst)
    i_test |=> hist_reg[0] == expand($past(lfsr_reg[3:0])))
    else $error("test pattern not on all channels");
endmodule // lac_front

/* File: hw/lac_pkg.sv */
// Shared constants and types for the logic acquisition front end
package lac_pkg;
  // ==========================================================
  // Geometry
  localparam int POD_W    = 17;
  localparam int NUM_PODS = 2;
  localparam int UNIT_W   = 34;
  localparam int CMP_W    = 9;
  localparam int NUM_CMP  = 4;
  localparam int CD_BIT   = 16;
  localparam int NUM_SCLK = 6;
  localparam int NUM_THR  = 8;
  localparam int THR_W    = 8;
  localparam int TAPS     = 4;
  localparam int TAP_W    = 2;
  localparam int DIV_W    = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int MAX_CLKS   = 6;
  // ==========================================================
  // Counts and reset values
  localparam int OPT_W = 5;
  localparam logic [OPT_W-1:0] OPT_EDGES = 5'h10;
  localparam logic [THR_W-1:0] THR_RST   = 8'h00;
  localparam logic [7:0]       LFSR_SEED = 8'h01;
  localparam logic [TAP_W-1:0] TAP_RST   = 2'h0;
  localparam logic [DIV_W-1:0] DIV_RST   = 8'h00;
  localparam logic [1:0]       PHASE_RST = 2'h0;
  // ==========================================================
  // Types
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_OPT  = 3'b010,
    ST_RUN  = 3'b100
  } lac_state_t;

  typedef struct packed
  {
    logic [UNIT_W-1:0] data;
    logic [1:0]        phase;
    logic              tst;
  } lac_smp_t;
endpackage

/* File: test/lac_front_tb.sv */
// Self-checking bench for the acquisition unit front end
`timescale 1ns/100ps
module lac_front_tb;
  import lac_pkg::*;
  // Narrow variant: only four state clock lines may be assigned
  localparam int NCLK = 4;
  logic                        i_clk, i_rst, i_sync, i_run, i_timing;
  logic                        i_slow_sel, i_div_master, i_test;
  logic                        i_thr_wr, i_ready;
  logic [DIV_W-1:0]            i_div;
  logic [3:0]                  i_phase_mask;
  logic [NUM_SCLK-1:0]         i_clk_en, sclk;
  logic [2:0]                  i_thr_idx;
  logic [THR_W-1:0]            i_thr_val;
  logic [NUM_PODS*POD_W-1:0]   pod;
  lac_smp_t                    o_data;
  logic                        o_valid, o_slow_clk, o_running;
  logic                        o_overrun, o_test_err;
  logic [NUM_THR*THR_W-1:0]    o_thresh, thr;
  logic [TAP_W-1:0]            o_tap;
  logic [UNIT_W-1:0]           d;
  int                          fail_count, num_checks, seed, cnt, p;

  lac_target i_lac_target (.i_clk(i_clk), .o_pod(pod), .o_sclk(sclk));
  // Master loops its own slow clock back, as the shared pin would
  lac_front #(.NCLK_CAP(NCLK), .CD_BASE(0)) i_lac_front (
    .i_clk(i_clk), .i_rst(i_rst), .i_pod(pod), .i_sclk(sclk),
    .i_sync(i_sync), .i_slow_clk(o_slow_clk), .i_run(i_run),
    .i_timing(i_timing), .i_slow_sel(i_slow_sel),
    .i_div_master(i_div_master), .i_div(i_div),
    .i_phase_mask(i_phase_mask), .i_clk_en(i_clk_en), .i_test(i_test),
    .i_thr_wr(i_thr_wr), .i_thr_idx(i_thr_idx), .i_thr_val(i_thr_val),
    .i_ready(i_ready), .o_data(o_data), .o_valid(o_valid),
    .o_thresh(o_thresh), .o_slow_clk(o_slow_clk), .o_running(o_running),
    .o_tap(o_tap), .o_overrun(o_overrun), .o_test_err(o_test_err));

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Clock-or-data pin reads 0 only when it is an assignable clock
  function automatic logic [UNIT_W-1:0] exp_data(
    input logic [UNIT_W-1:0] v, input logic st, input logic [5:0] en);
    logic [UNIT_W-1:0] r;
    r = v;
    for (int k = 0; k < NUM_PODS; k++)
      if (st && k < NCLK && en[k])
        r[k*POD_W+CD_BIT] = 1'b0;
    return r;
  endfunction
  // Run is restarted from idle so that the mode inputs are latched
  task automatic start(input logic tm, input logic sl, input logic ms,
                       input logic [5:0] en, input logic [3:0] pm);
    @(posedge i_clk);
    #1;
    i_run = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    {i_timing, i_slow_sel, i_div_master, i_clk_en} = {tm, sl, ms, en};
    i_phase_mask = pm;
    @(posedge i_clk);
    #1;
    i_run = 1'b1;
  endtask
  task automatic wait_run(input int lim);
    for (int k = 0; k < lim && o_running !== 1'b1; k++)
    begin
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic collect(input int n, input logic cd, input logic cp,
                         input logic [1:0] ph, input logic ts);
    cnt = 0;
    repeat (n)
    begin
      @(posedge i_clk);
      #1;
      if (o_valid === 1'b1)
      begin
        cnt++;
        if (cd) check(o_data.data, d);
        if (cp) check(o_data.phase, ph);
        check(o_data.tst, ts);
      end
    end
  endtask
  // Cycles between two rises of the slow sample clock
  task automatic period(output int r);
    logic prv;
    int   t0;
    prv = 1'b1;
    t0  = -1;
    r   = 0;
    for (int k = 0; k < 300 && r == 0; k++)
    begin
      @(posedge i_clk);
      #1;
      if (o_slow_clk === 1'b1 && prv === 1'b0)
      begin
        if (t0 >= 0)
          r = k - t0;
        else
          t0 = k;
      end
      prv = o_slow_clk;
    end
  endtask
  // ==========================================================
  // Watchdog: the whole sequence needs well under 20k cycles
  initial
  begin
    #(40 * 60000);
    fail_count++;
    results();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {i_rst, i_sync, i_run, i_timing, i_slow_sel, i_div_master} = 6'h21;
    {i_test, i_thr_wr, i_ready} = 3'h1;
    {i_div, i_phase_mask, i_clk_en, i_thr_idx, i_thr_val} = '0;
    fail_count = 0;
    num_checks = 0;
    seed = 84;
    thr = '0;
    repeat (5) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    check({o_valid, o_running, o_tap, o_overrun, o_test_err}, 0);
    check(o_thresh, {NUM_THR{THR_RST}});
    // Back-to-back threshold writes, each pod on its own
    for (int k = 0; k < 24; k++)
    begin
      i_thr_wr  = 1'b1;
      i_thr_idx = (k < 8) ? k[2:0] : 3'($random(seed));
      i_thr_val = 8'($random(seed));
      @(posedge i_clk);
      #1;
      thr[i_thr_idx*THR_W +: THR_W] = i_thr_val;
      check(o_thresh, thr);
    end
    i_thr_wr = 1'b0;
    // Clock line past the cap never clocks: run stays optimising
    start(1'b0, 1'b0, 1'b0, 6'h10, 4'h0);
    i_lac_target.strobe(4, 20, 4);
    check(o_running, 1'b0);
    // State mode: optimisation needs exactly sixteen edges
    d = UNIT_W'({$random(seed), $random(seed)}) | 34'h2_0001_0000;
    i_lac_target.put(d);
    start(1'b0, 1'b0, 1'b0, 6'h03, 4'h0);
    i_lac_target.strobe(0, 15, 5);
    repeat (6) @(posedge i_clk);
    #1;
    check(o_running, 1'b0);
    i_lac_target.strobe(0, 1, 5);
    wait_run(10);
    check(o_running, 1'b1);
    check(o_tap, TAP_RST);
    d = exp_data(d, 1'b1, 6'h03);
    fork
      i_lac_target.strobe(0, 4, 7);
      collect(80, 1'b1, 1'b0, 2'h0, 1'b0);
    join
    check(64'(cnt), 64'd4);
    // Fast timing: cd pins are data, one word per chosen phase tick
    i_sync = 1'b1;
    @(posedge i_clk);
    #1;
    i_sync = 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      d = UNIT_W'({$random(seed), $random(seed)}) | 34'h2_0001_0000;
      i_lac_target.put(d);
      start(1'b1, 1'b0, 1'b0, 6'h03, 4'(1 << m));
      wait_run(200);
      collect(20, 1'b0, 1'b0, 2'h0, 1'b0);
      collect(40, 1'b1, 1'b1, 2'(m), 1'b0);
      check(64'(cnt), 64'd10);
    end
    // Slow timing master: divider period, mode held while running
    for (int k = 0; k < 2; k++)
    begin
      i_div = (k == 0) ? DIV_RST : 8'(1 + ($random(seed) & 3));
      start(1'b1, 1'b1, 1'b1, 6'h00, 4'h1);
      period(p);
      check(64'(p), 64'(8 * (i_div + 1)));
      wait_run(700);
      check(o_running, 1'b1);
      i_div_master = 1'b0;
      period(p);
      check(64'(p), 64'(8 * (i_div + 1)));
    end
    start(1'b1, 1'b1, 1'b0, 6'h00, 4'h1);
    p = 0;
    repeat (80)
    begin
      @(posedge i_clk);
      #1;
      p += int'(o_slow_clk === 1'b1);
    end
    check(64'(p), 64'd0);
    // Stalled sink fills the FIFO until samples are refused
    i_ready = 1'b0;
    start(1'b1, 1'b0, 1'b0, 6'h00, 4'hF);
    wait_run(100);
    repeat (20) @(posedge i_clk);
    #1;
    check({o_overrun, o_valid}, 2'h3);
    d = o_data.data;
    repeat (3) @(posedge i_clk);
    #1;
    check(o_data.data, d);
    i_run = 1'b0;
    i_ready = 1'b1;
    cnt = 0;
    for (int k = 0; k < 40 && o_valid === 1'b1; k++)
    begin
      @(posedge i_clk);
      #1;
      cnt++;
    end
    check({o_valid, 1'(cnt >= FIFO_DEPTH)}, 2'h1);
    // Self-test pattern; the next run start clears the overrun
    i_test = 1'b1;
    start(1'b1, 1'b0, 1'b0, 6'h00, 4'h1);
    repeat (3) @(posedge i_clk);
    #1;
    check(o_overrun, 1'b0);
    wait_run(200);
    collect(60, 1'b0, 1'b0, 2'h0, 1'b1);
    check({o_test_err, 1'(cnt > 0)}, 2'h1);
    // Reset in mid-run returns o_valid, o_running, o_slow_clk, o_tap, o_test_err and o_thresh to reset values
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    check({o_valid, o_running, o_slow_clk, o_tap, o_test_err}, 0);
    check(o_thresh, {NUM_THR{THR_RST}});
    i_rst = 1'b0;
    results();
  end
endmodule // lac_front_tb

/* File: test/lac_target.sv */
// Probed target system model: pod pins and state clock lines
`timescale 1ns/100ps
module lac_target
  import lac_pkg::*;
(
  // Clock
  input  wire logic                  i_clk,
  // Pins towards the acquisition unit
  output logic [NUM_PODS*POD_W-1:0]  o_pod,
  output logic [NUM_SCLK-1:0]        o_sclk
);
  initial
  begin
    o_pod  = '0;
    o_sclk = '0;
  end
  // ==========================================================
  // Target activity
  // New pod word; held steady across the clock edges that follow
  task automatic put(input logic [NUM_PODS*POD_W-1:0] d);
    @(posedge i_clk);
    #1;
    o_pod = d;
  endtask
  // A clock line stands low between strobes; gap makes a slow target
  task automatic strobe(input int line, input int n, input int gap);
    for (int k = 0; k < n; k++)
    begin
      repeat (gap) @(posedge i_clk);
      #1;
      o_sclk[line] = 1'b1;
      repeat (gap) @(posedge i_clk);
      #1;
      o_sclk[line] = 1'b0;
    end
  endtask
endmodule // lac_target
